//--- include/sram_ctl_pkg.sv
// Shared constants and types for the synchronous SRAM control block
package sram_ctl_pkg;

    // ----------------------------------------
    // Constants and types
    // ----------------------------------------
    localparam int AXI_AW = 4;
    localparam int DATA_W = 32;
    localparam int BYTES = 4;
    localparam logic [AXI_AW-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [AXI_AW-1:0] STATUS_OFFSET = 4'h4;
    localparam logic [AXI_AW-1:0] VIOL_OFFSET = 4'h8;
    localparam int CTRL_NON_BURST_BIT = 0;
    localparam logic [0:0] CTRL_RESET = 1'h0;
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_SELECTED_BIT = 2;
    localparam int STATUS_CLOCK_ON_BIT = 3;
    localparam int STATUS_SLEEP_PIN_BIT = 4;
    localparam int VIOL_STROBE_BIT = 0;
    localparam int VIOL_WRITE_BIT = 1;
    localparam logic [1:0] VIOL_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLEEP_ENTRY_NS = 2 * CLK_PERIOD_NS;
    localparam int SLEEP_RECOVERY_NS = 2 * CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
    localparam int SLEEP_RECOVERY_CYC = (SLEEP_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 3;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_ENTERING,
        ST_ASLEEP,
        ST_RECOVERING
    } sleep_state_t;

endpackage

//--- logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for an asynchronous pin
`timescale 1ns/100ps
module pin_sync (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin_in,
    output logic level_out
);

    logic meta_ff;
    logic s2_ff;
    logic s3_ff;

    // ----------------------------------------
    // Capture chain and agreement filter
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            s2_ff <= meta_ff;
            s3_ff <= s2_ff;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level_out <= 1'b0;
        end else if (s2_ff == s3_ff) begin
            level_out <= s3_ff;
        end
    end

endmodule

//--- logic/sram_array.sv
// Byte-writable storage array with registered read port
`timescale 1ns/100ps
module sram_array #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic rd_en,
    input wire logic [sram_ctl_pkg::BYTES-1:0] wr_mask,
    input wire logic [sram_ctl_pkg::DATA_W-1:0] wr_data,
    output logic [sram_ctl_pkg::DATA_W-1:0] rd_data
);
    import sram_ctl_pkg::*;

    logic [DATA_W-1:0] mem_ff [2**ADDR_W];

    // ----------------------------------------
    // Byte writes and read register
    // ----------------------------------------
    always_ff @(posedge clk) begin
        for (int b = 0; b < BYTES; b++) begin
            if (wr_mask[b]) begin
                mem_ff[addr][b*8 +: 8] <= wr_data[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem_ff[addr];
        end
    end

endmodule

//--- logic/sram_sleep_ctl.sv
// Pipelined synchronous SRAM control, sleep logic and AXI4-Lite status port
//
// Notes on behaviour
// - Write inputs count only when selected, processor strobe idle
// - Chip enables sampled only on an address strobe
// - Output enable ignored once a write began
// - Sleep request puts device in lowest power
// - Read data invalid once sleep requested
// - Device deselects itself entering sleep
// - Internal clock gated off while asleep
// - Asleep: inputs ignored, no read or write
// - Non-burst tie-offs give one address per cycle
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
module sram_sleep_ctl #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [sram_ctl_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sram_ctl_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ADDR_W-1:0] address,
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic burst_advance_n,
    input wire logic first_chip_enable_n,
    input wire logic second_chip_enable,
    input wire logic third_chip_enable_n,
    input wire logic [sram_ctl_pkg::BYTES-1:0] byte_write_select_n,
    input wire logic write_qualifier_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_select,
    input wire logic [sram_ctl_pkg::DATA_W-1:0] data_in,
    output logic [sram_ctl_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic internal_clock_on
);
    import sram_ctl_pkg::*;

    // ----------------------------------------
    // Helpers and declarations
    // ----------------------------------------
    function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] cnt, input logic order);
        return order ? 2'(base + cnt) : (base ^ cnt);
    endfunction

    sleep_state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [0:0] ctrl_ff;
    logic [1:0] viol_ff, base_lo_ff, burst_cnt_ff, nxt_cnt;
    logic [ADDR_W-1:0] addr_ff, acc_addr;
    logic [DATA_W-1:0] rd_q;
    logic [BYTES-1:0] wr_mask;
    logic [AXI_AW-1:0] awaddr_ff;
    logic [31:0] wdata_ff, rd_word;
    logic [3:0] wstrb_ff;
    logic sleep_req_s, selected_ff, order_ff, rd_pipe_ff, out_valid_ff, write_active_ff, aw_hold_ff, w_hold_ff;
    logic non_burst, p_strobe, c_strobe, burst_advance, ce1_n, strobe, sel_now, awake, advance, access, write_req;
    logic wr_en, rd_en, quiet, do_write, rd_hit;

    // ----------------------------------------
    // Sleep pin and state machine
    // ----------------------------------------
    // sleep pin capture
    pin_sync u_sleep_sync (
        .clk(clk),
        .resetn(resetn),
        .pin_in(sleep_request),
        .level_out(sleep_req_s)
    );
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= ST_NORMAL;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                ST_NORMAL: begin
                    if (sleep_req_s) begin
                        state_ff <= ST_ENTERING;
                        cnt_ff <= CNT_W'(SLEEP_ENTRY_CYC > 1 ? SLEEP_ENTRY_CYC - 2 : 0);
                    end
                end
                ST_ENTERING: begin
                    if (cnt_ff == '0) begin
                        state_ff <= ST_ASLEEP;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_ASLEEP: begin
                    if (!sleep_req_s) begin
                        state_ff <= ST_RECOVERING;
                        cnt_ff <= CNT_W'(SLEEP_RECOVERY_CYC - 1);
                    end
                end
                ST_RECOVERING: begin
                    if (sleep_req_s) begin
                        state_ff <= ST_ENTERING;
                        cnt_ff <= '0;
                    end else if (cnt_ff == '0) begin
                        state_ff <= ST_NORMAL;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= ST_NORMAL;
                    cnt_ff <= '0;
                end
            endcase
        end
    end

    assign internal_clock_on = (state_ff != ST_ASLEEP);
    assign awake = (state_ff == ST_NORMAL) && !sleep_req_s;

    // ----------------------------------------
    // Control qualification
    // ----------------------------------------
    // non-burst tie-offs
    assign non_burst = ctrl_ff[CTRL_NON_BURST_BIT];
    assign p_strobe = non_burst ? 1'b0 : !processor_address_strobe_n;
    assign c_strobe = non_burst ? 1'b1 : !controller_address_strobe_n;
    assign burst_advance = non_burst ? 1'b0 : !burst_advance_n;
    assign ce1_n = non_burst ? 1'b0 : first_chip_enable_n;
    assign strobe = p_strobe || c_strobe;

    assign sel_now = !ce1_n && second_chip_enable && !third_chip_enable_n;
    assign advance = !strobe && selected_ff && burst_advance;
    assign access = awake && ((strobe && sel_now) || advance);

    assign write_req = !global_write_n || (!write_qualifier_n && (byte_write_select_n != '1));
    assign wr_en = access && !p_strobe && write_req;
    assign wr_mask = !wr_en ? '0 : (!global_write_n ? '1 : ~byte_write_select_n);
    assign rd_en = access && !wr_en;

    assign nxt_cnt = 2'(burst_cnt_ff + 2'h1);
    assign acc_addr = strobe ? address : {addr_ff[ADDR_W-1:2], burst_low(base_lo_ff, nxt_cnt, order_ff)};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            selected_ff <= 1'b0;
        end else if (!awake) begin
            selected_ff <= 1'b0;
        end else if (strobe) begin
            selected_ff <= sel_now;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_ff <= '0;
            base_lo_ff <= '0;
            burst_cnt_ff <= '0;
            order_ff <= 1'b0;
        end else if (access && strobe) begin
            addr_ff <= address;
            base_lo_ff <= address[1:0];
            burst_cnt_ff <= '0;
            order_ff <= burst_order_select;
        end else if (access) begin
            addr_ff <= acc_addr;
            burst_cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------
    // Storage and output pipeline
    // ----------------------------------------
    sram_array #(
        .ADDR_W(ADDR_W)
    ) u_array (
        .clk(clk),
        .resetn(resetn),
        .addr(acc_addr),
        .rd_en(rd_en),
        .wr_mask(wr_mask),
        .wr_data(data_in),
        .rd_data(rd_q)
    );
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_pipe_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            data_out <= '0;
        end else begin
            rd_pipe_ff <= rd_en;
            out_valid_ff <= rd_pipe_ff && awake;
            if (rd_pipe_ff) begin
                data_out <= rd_q;
            end
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            write_active_ff <= 1'b0;
        end else begin
            write_active_ff <= wr_en;
        end
    end

    assign data_oe = out_valid_ff && !output_enable_n && !wr_en && !write_active_ff;

    // ----------------------------------------
    // Violation flags and registers
    // ----------------------------------------
    // quiet window watch
    assign quiet = (state_ff != ST_NORMAL) || sleep_req_s;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            viol_ff <= VIOL_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (do_write && awaddr_ff == VIOL_OFFSET && wstrb_ff[0] && wdata_ff[i]) begin
                    viol_ff[i] <= 1'b0;
                end
            end
            if (quiet && (!processor_address_strobe_n || !controller_address_strobe_n)) begin
                viol_ff[VIOL_STROBE_BIT] <= 1'b1;
            end
            if (quiet && write_req) begin
                viol_ff[VIOL_WRITE_BIT] <= 1'b1;
            end
        end
    end

    assign s_axi_awready = !aw_hold_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_ff && !s_axi_bvalid;
    assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (do_write) begin
            aw_hold_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            w_hold_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (do_write) begin
            w_hold_ff <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awaddr_ff == CTRL_OFFSET || awaddr_ff == VIOL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= CTRL_RESET;
        end else if (do_write && awaddr_ff == CTRL_OFFSET && wstrb_ff[0]) begin
            ctrl_ff[CTRL_NON_BURST_BIT] <= wdata_ff[CTRL_NON_BURST_BIT];
        end
    end

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            CTRL_OFFSET: rd_word[CTRL_NON_BURST_BIT] = ctrl_ff[CTRL_NON_BURST_BIT];
            STATUS_OFFSET: begin
                rd_word[STATUS_STATE_LSB +: 2] = state_ff;
                rd_word[STATUS_SELECTED_BIT] = selected_ff;
                rd_word[STATUS_CLOCK_ON_BIT] = internal_clock_on;
                rd_word[STATUS_SLEEP_PIN_BIT] = sleep_req_s;
            end
            VIOL_OFFSET: rd_word[1:0] = viol_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

//--- verification/sram_sleep_ctl_chk.sv
// Assertion checker for the SRAM control pins
`timescale 1ns/100ps
module sram_sleep_ctl_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic first_chip_enable_n,
    input wire logic second_chip_enable,
    input wire logic third_chip_enable_n,
    input wire logic [sram_ctl_pkg::BYTES-1:0] byte_write_select_n,
    input wire logic write_qualifier_n,
    input wire logic global_write_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [sram_ctl_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic internal_clock_on
);
    import sram_ctl_pkg::*;
    logic [3:0] quiet_ff;
    logic sel;
    logic strobe;
    logic wr_cmd;
    logic rd_cmd;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    assign sel = !first_chip_enable_n && second_chip_enable && !third_chip_enable_n;
    assign strobe = !processor_address_strobe_n || !controller_address_strobe_n;
    assign wr_cmd = processor_address_strobe_n && !controller_address_strobe_n && sel
        && (!global_write_n || (!write_qualifier_n && byte_write_select_n != 4'hf));
    assign rd_cmd = strobe && sel && !wr_cmd && quiet_ff == 4'hf;
    // Cycles awake since sleep last seen
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            quiet_ff <= 4'h0;
        end else if (!internal_clock_on || sleep_request) begin
            quiet_ff <= 4'h0;
        end else if (quiet_ff != 4'hf) begin
            quiet_ff <= quiet_ff + 4'h1;
        end
    end
    chk_oe_pin_off: assert property (output_enable_n |-> !data_oe)
        else $error("data bus driven with output enable high");
    chk_write_no_oe: assert property (wr_cmd && quiet_ff == 4'hf |=> !data_oe)
        else $error("data bus driven in write cycle");
    chk_read_lat: assert property (rd_cmd ##1 !wr_cmd ##1 !wr_cmd |-> output_enable_n || data_oe)
        else $error("read data not driven after read");
    chk_desel_idle: assert property (strobe && !sel && quiet_ff == 4'hf |-> ##2 !data_oe)
        else $error("deselected access drove the bus");
    chk_sleep_entry: assert property ($rose(sleep_request) |-> ##[1:10] (!internal_clock_on || !sleep_request))
        else $error("sleep not entered in time");
    chk_sleep_wake: assert property ($fell(sleep_request) |-> ##[1:12] (internal_clock_on || sleep_request))
        else $error("clock not restored after sleep");
    chk_asleep_quiet: assert property (!internal_clock_on |-> !data_oe)
        else $error("bus driven while asleep");
    chk_frozen_out: assert property (!internal_clock_on ##1 !internal_clock_on |-> $stable(data_out))
        else $error("read data changed while asleep");
    cov_read: cover property (rd_cmd ##2 data_oe);
    cov_write: cover property (wr_cmd && quiet_ff == 4'hf);
    cov_wake: cover property (!internal_clock_on ##1 internal_clock_on);
endmodule

bind sram_sleep_ctl sram_sleep_ctl_chk chk (.clk, .resetn, .processor_address_strobe_n, .controller_address_strobe_n,
    .first_chip_enable_n, .second_chip_enable, .third_chip_enable_n, .global_write_n, .output_enable_n,
    .sleep_request, .data_out, .data_oe, .internal_clock_on, .byte_write_select_n, .write_qualifier_n);

//--- verification/cache_master.sv
// Bus master model driving the SRAM pins
`timescale 1ns/100ps
module cache_master #(
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    output logic [ADDR_W-1:0] address,
    output logic processor_address_strobe_n,
    output logic controller_address_strobe_n,
    output logic burst_advance_n,
    output logic first_chip_enable_n,
    output logic second_chip_enable,
    output logic third_chip_enable_n,
    output logic [sram_ctl_pkg::BYTES-1:0] byte_write_select_n,
    output logic write_qualifier_n,
    output logic global_write_n,
    output logic output_enable_n,
    output logic sleep_request,
    output logic burst_order_select,
    output logic [sram_ctl_pkg::DATA_W-1:0] data_in
);
    import sram_ctl_pkg::*;
    initial begin
        address = 4'h0;
        processor_address_strobe_n = 1'b1;
        controller_address_strobe_n = 1'b1;
        burst_advance_n = 1'b1;
        {first_chip_enable_n, second_chip_enable, third_chip_enable_n} = 3'h2;
        byte_write_select_n = 4'hf;
        write_qualifier_n = 1'b1;
        global_write_n = 1'b1;
        output_enable_n = 1'b1;
        sleep_request = 1'b0;
        burst_order_select = 1'b0;
        data_in = 32'h0;
    end
    task automatic idle();
        @(posedge clk);
        processor_address_strobe_n <= 1'b1;
        controller_address_strobe_n <= 1'b1;
        byte_write_select_n <= 4'hf;
        write_qualifier_n <= 1'b1;
        global_write_n <= 1'b1;
        address <= ~address;
        data_in <= ~data_in;
    endtask
    task automatic cmd(input logic ps_n, input logic [2:0] en, input logic [3:0] bw_n, input logic gw_n,
        input logic wq_n, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic rude);
        logic wr;
        wr = !gw_n || !wq_n;
        if (wr && !rude && !output_enable_n) begin
            @(posedge clk);
            output_enable_n <= 1'b1;
        end
        @(posedge clk);
        processor_address_strobe_n <= ps_n;
        controller_address_strobe_n <= 1'b0;
        {first_chip_enable_n, second_chip_enable, third_chip_enable_n} <= en;
        byte_write_select_n <= bw_n;
        write_qualifier_n <= wq_n;
        global_write_n <= gw_n;
        address <= a;
        data_in <= d;
        if (!wr) begin
            output_enable_n <= 1'b0;
        end
    endtask
    task automatic sleep_pin(input logic v);
        @(posedge clk);
        sleep_request <= v;
    endtask
    task automatic storm(input logic [ADDR_W-1:0] a, input int n);
        repeat (n) begin
            @(posedge clk);
            processor_address_strobe_n <= ~processor_address_strobe_n;
            controller_address_strobe_n <= 1'b0;
            global_write_n <= processor_address_strobe_n;
            address <= a;
            data_in <= ~data_in;
        end
    endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the SRAM sleep and select control
`timescale 1ns/100ps
module tb;
    import sram_ctl_pkg::*;
    localparam int AW = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, data_in, data_out, rv;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, data_oe, internal_clock_on;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [AW-1:0] address;
    logic processor_address_strobe_n, controller_address_strobe_n, burst_advance_n, first_chip_enable_n;
    logic second_chip_enable, third_chip_enable_n, write_qualifier_n, global_write_n, output_enable_n;
    logic sleep_request, burst_order_select;
    logic [3:0] byte_write_select_n;
    int fails = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    sram_sleep_ctl #(.ADDR_W(AW)) DUT (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .address, .processor_address_strobe_n, .controller_address_strobe_n, .burst_advance_n,
        .first_chip_enable_n, .second_chip_enable, .third_chip_enable_n, .byte_write_select_n,
        .write_qualifier_n, .global_write_n, .output_enable_n, .sleep_request, .burst_order_select,
        .data_in, .data_out, .data_oe, .internal_clock_on);
    cache_master #(.ADDR_W(AW)) master (.clk, .address, .processor_address_strobe_n,
        .controller_address_strobe_n, .burst_advance_n, .first_chip_enable_n, .second_chip_enable,
        .third_chip_enable_n, .byte_write_select_n, .write_qualifier_n, .global_write_n, .output_enable_n,
        .sleep_request, .burst_order_select, .data_in);

    task automatic check(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] d);
        logic done, aw_t, w_t, ar_t;
        done = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        for (int n = 0; n < 40 && !done; n++) begin
            @(negedge clk);
            aw_t = s_axi_awvalid && s_axi_awready;
            w_t = s_axi_wvalid && s_axi_wready;
            ar_t = s_axi_arvalid && s_axi_arready;
            done = (s_axi_bvalid && s_axi_bready) === 1'b1 || (s_axi_rvalid && s_axi_rready) === 1'b1;
            rv = s_axi_rdata;
            rr = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
            if (ar_t) s_axi_arvalid <= 1'b0;
            if (done) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
        if (!done) begin
            check(1'b0, "bus answer timed out");
            end_of_test();
        end
    endtask
    task automatic reg_check(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        axi(1'b0, a, 32'h0);
        check(rr === r && (rv & m) === e, "register read");
    endtask
    task automatic pin_read(input logic [AW-1:0] a, input logic [31:0] e);
        master.cmd(1'b1, 3'h2, 4'hf, 1'b1, 1'b1, a, 32'h0, 1'b0);
        repeat (2) master.idle();
        #1;
        check(data_oe === 1'b1 && data_out === e, "pin read data");
    endtask
    task automatic wait_clk_on(input logic v);
        int n;
        for (n = 0; n < 12 && internal_clock_on !== v; n++) begin
            @(posedge clk) #1;
        end
        check(internal_clock_on === v, "internal clock level");
        if (n == 12) end_of_test();
    endtask

    task automatic t_regs();
        reg_check(CTRL_OFFSET, 32'h1, {31'h0, CTRL_RESET}, RESP_OKAY);
        reg_check(STATUS_OFFSET, 32'h1b, 32'h8, RESP_OKAY);
        reg_check(VIOL_OFFSET, 32'h3, {30'h0, VIOL_RESET}, RESP_OKAY);
        reg_check(4'hc, 32'hffffffff, 32'h0, RESP_SLVERR);
        axi(1'b1, 4'hc, 32'h1);
        check(rr === RESP_SLVERR, "unmapped write");
        axi(1'b1, CTRL_OFFSET, 32'h1);
        reg_check(CTRL_OFFSET, 32'h1, 32'h1, RESP_OKAY);
        master.cmd(1'b0, 3'h6, 4'hf, 1'b0, 1'b1, 4'h5, 32'h5a5a0005, 1'b0);
        master.idle();
        axi(1'b1, CTRL_OFFSET, 32'h0);
        pin_read(4'h5, 32'h5a5a0005);
        $display("registers and non-burst done");
    endtask
    task automatic t_select();
        logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
        master.cmd(1'b1, 3'h2, 4'hf, 1'b0, 1'b1, 4'h3, 32'h11223344, 1'b0);
        master.cmd(1'b1, 3'h2, 4'ha, 1'b1, 1'b0, 4'h3, 32'haabbccdd, 1'b0);
        master.cmd(1'b0, 3'h2, 4'h0, 1'b0, 1'b0, 4'h3, 32'h0, 1'b0);
        pin_read(4'h3, 32'h11bb33dd);
        foreach (bad[i]) begin
            master.cmd(1'b1, bad[i], 4'h0, 1'b0, 1'b0, 4'h3, 32'hffffffff, 1'b0);
            pin_read(4'h3, 32'h11bb33dd);
        end
        master.cmd(1'b1, 3'h2, 4'hf, 1'b1, 1'b1, 4'h3, 32'h0, 1'b0);
        master.cmd(1'b1, 3'h2, 4'hf, 1'b0, 1'b1, 4'h3, 32'h0f0f0f0f, 1'b1);
        master.idle();
        #1;
        check(data_oe === 1'b0, "bus driven during write");
        pin_read(4'h3, 32'h0f0f0f0f);
        $display("select and write qualification done");
    endtask
    task automatic t_sleep();
        master.cmd(1'b1, 3'h2, 4'h0, 1'b1, 1'b0, 4'h7, 32'h0bad0007, 1'b0);
        repeat (3) master.idle();
        master.sleep_pin(1'b1);
        wait_clk_on(1'b0);
        reg_check(STATUS_OFFSET, 32'h1f, 32'h12, RESP_OKAY);
        master.storm(4'h7, 6);
        master.idle();
        reg_check(VIOL_OFFSET, 32'h3, 32'h3, RESP_OKAY);
        axi(1'b1, VIOL_OFFSET, 32'h3);
        reg_check(VIOL_OFFSET, 32'h3, 32'h0, RESP_OKAY);
        master.sleep_pin(1'b0);
        wait_clk_on(1'b1);
        repeat (SLEEP_RECOVERY_CYC + 6) master.idle();
        pin_read(4'h7, 32'h0bad0007);
        $display("sleep done");
    endtask

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_select();
        t_sleep();
        end_of_test();
    end
endmodule
